// file: verilog/gpio_exp_pkg.sv
// What this block does
// - master starts only on idle bus
// - answer address 0x20 or 0x21 by select pin
// - address last bit: one read, zero write
// - write: start, address, command, data, stop
// - read: write command, restart, read address
// - master acks for more, nacks last; release
// - no command byte without write addressing
// - first byte after write address is command
// - low two command bits select register
// - input register shows pins; writes ignored
// - output latch drives outputs; resets ones
// - output latch reads stored values
// - invert bit flips reported input; resets zeros
// - direction one input, zero output; resets ones
// - input pin edges assert active-low interrupt
// - interrupt clears on return or port read
// - outputs never interrupt; switching may
// - reset pin low forces all defaults
package gpio_exp_pkg;
  localparam int PORT_W = 8;
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // register codes in the low command bits
  localparam logic [1:0] SEL_PIN_LEVEL = 2'h0;
  localparam logic [1:0] SEL_OUTPUT_LATCH = 2'h1;
  localparam logic [1:0] SEL_INPUT_INVERT = 2'h2;
  localparam logic [1:0] SEL_PIN_DIRECTION = 2'h3;
  localparam logic [7:0] OUTPUT_LATCH_RST = 8'hFF;
  localparam logic [7:0] INPUT_INVERT_RST = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_RST = 8'hFF;
  localparam logic [7:0] COMMAND_RST = 8'h00;
  // host command port map
  localparam logic [2:0] HREG_SLAVE = 3'h0;
  localparam logic [2:0] HREG_COMMAND = 3'h1;
  localparam logic [2:0] HREG_WDATA = 3'h2;
  localparam logic [2:0] HREG_CTRL = 3'h3;
  localparam logic [2:0] HREG_STATUS = 3'h4;
  localparam logic [2:0] HREG_RDATA = 3'h5;
  // host bus timing: quarter of an scl period
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUARTER_NS = 625;
  localparam int QUARTER_CYCLES = QUARTER_NS / CLK_PERIOD_NS;
  // device bus states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_WR = 4'h5,
    ST_WR_ACK = 4'h6,
    ST_RD = 4'h7,
    ST_RD_ACK = 4'h8
  } dev_state_e;
  // host bus elements
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_XFER = 2'h2,
    H_STOP = 2'h3
  } host_op_e;
endpackage

// file: verilog/i2c_exp_if.sv
`timescale 1ns/1ps
interface i2c_exp_if;
  logic scl_out;
  logic scl_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic int_out;
  logic int_oe;
  logic scl;
  logic sda;
  logic int_n;
  // open-drain wires with pull-ups
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = (sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out) ? 1'b0 : 1'b1;
  assign int_n = int_oe ? int_out : 1'b1;
  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe,
    output int_out, output int_oe);
  modport host (output scl_out, output scl_oe, output sda_host_out, output sda_host_oe,
    input scl, input sda, input int_n);
endinterface

// file: verilog/io_expander_dev.sv
`timescale 1ns/1ps
module io_expander_dev (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  i2c_exp_if.device bus,
  input wire logic addr_sel_in,
  input wire logic reset_pin_n_in,
  input wire logic [gpio_exp_pkg::PORT_W-1:0] port_pin_in,
  output logic [gpio_exp_pkg::PORT_W-1:0] port_pin_out,
  output logic [gpio_exp_pkg::PORT_W-1:0] port_pin_oe_out
);
  logic scl_meta;
  logic scl_s;
  logic scl_d;
  logic sda_meta;
  logic sda_s;
  logic sda_d;
  logic sel_meta;
  logic sel_s;
  logic rstn_meta;
  logic rstn_s;
  logic [7:0] pin_meta;
  logic [7:0] pin_s;
  gpio_exp_pkg::dev_state_e state;
  gpio_exp_pkg::dev_state_e next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic sda_low;
  logic next_sda_low;
  logic is_read;
  logic next_is_read;
  logic [7:0] command_pointer;
  logic [7:0] output_latch;
  logic [7:0] input_invert;
  logic [7:0] pin_direction;
  logic [7:0] snapshot;
  logic [7:0] load_pins;
  logic [2:0] prime_sr;
  logic int_active;

  // two-flop synchronisers for every pin input
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
      {sel_meta, sel_s} <= 2'h0;
      {rstn_meta, rstn_s} <= 2'h3;
      pin_meta <= 8'h00;
      pin_s <= 8'h00;
    end
    else
    begin
      {scl_meta, scl_s, scl_d} <= {bus.scl, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {bus.sda, sda_meta, sda_s};
      {sel_meta, sel_s} <= {addr_sel_in, sel_meta};
      {rstn_meta, rstn_s} <= {reset_pin_n_in, rstn_meta};
      pin_meta <= port_pin_in;
      pin_s <= pin_meta;
    end
  end

  // bus events and decodes
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire soft_clr = ~rstn_s;
  wire byte_done = bitcnt == gpio_exp_pkg::BITS_PER_BYTE;
  wire addr_match = shift[7:1] == {gpio_exp_pkg::SLAVE_ADDR_BASE[6:1], sel_s};
  wire [1:0] sel_code = command_pointer[1:0];
  wire [7:0] pin_view = pin_s ^ input_invert;
  wire [7:0] sel_value =
    (sel_code == gpio_exp_pkg::SEL_PIN_LEVEL) ? pin_view :
    (sel_code == gpio_exp_pkg::SEL_OUTPUT_LATCH) ? output_latch :
    (sel_code == gpio_exp_pkg::SEL_INPUT_INVERT) ? input_invert : pin_direction;
  wire cmd_load = scl_fall & (state == gpio_exp_pkg::ST_CMD) & byte_done;
  wire data_load = scl_fall & (state == gpio_exp_pkg::ST_WR) & byte_done;
  wire read_load = scl_fall & (((state == gpio_exp_pkg::ST_ADDR_ACK) & is_read)
    | (state == gpio_exp_pkg::ST_RD_ACK));
  wire read_ack_clk = scl_rise & (state == gpio_exp_pkg::ST_RD_ACK);
  wire [7:0] changed = (pin_s ^ snapshot) & pin_direction;
  // pin synchronisers hold real levels after two edges; reference is taken on the third
  wire primed = prime_sr[2];

  // bus state machine next values
  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shift = shift;
    next_sda_low = sda_low;
    next_is_read = is_read;
    if (stop_det)
    begin
      next_state = gpio_exp_pkg::ST_IDLE;
      next_sda_low = 1'b0;
    end
    else if (start_det)
    begin
      next_state = gpio_exp_pkg::ST_ADDR;
      next_bitcnt = 4'h0;
      next_sda_low = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state)
        gpio_exp_pkg::ST_ADDR, gpio_exp_pkg::ST_CMD, gpio_exp_pkg::ST_WR:
        begin
          next_shift = {shift[6:0], sda_s};
          next_bitcnt = bitcnt + 4'h1;
        end
        gpio_exp_pkg::ST_RD_ACK:
        begin
          if (sda_s)
            next_state = gpio_exp_pkg::ST_IDLE;
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (state)
        gpio_exp_pkg::ST_ADDR:
        begin
          if (byte_done && addr_match)
          begin
            next_state = gpio_exp_pkg::ST_ADDR_ACK;
            next_sda_low = 1'b1;
            next_is_read = shift[0];
          end
          else if (byte_done)
            next_state = gpio_exp_pkg::ST_IDLE;
        end
        gpio_exp_pkg::ST_ADDR_ACK, gpio_exp_pkg::ST_RD_ACK:
        begin
          if (is_read)
          begin
            next_state = gpio_exp_pkg::ST_RD;
            next_shift = sel_value;
            next_sda_low = ~sel_value[7];
            next_bitcnt = 4'h1;
          end
          else
          begin
            next_state = gpio_exp_pkg::ST_CMD;
            next_sda_low = 1'b0;
            next_bitcnt = 4'h0;
          end
        end
        gpio_exp_pkg::ST_CMD, gpio_exp_pkg::ST_WR:
        begin
          if (byte_done)
          begin
            next_state = (state == gpio_exp_pkg::ST_CMD) ? gpio_exp_pkg::ST_CMD_ACK
              : gpio_exp_pkg::ST_WR_ACK;
            next_sda_low = 1'b1;
          end
        end
        gpio_exp_pkg::ST_CMD_ACK, gpio_exp_pkg::ST_WR_ACK:
        begin
          next_state = gpio_exp_pkg::ST_WR;
          next_sda_low = 1'b0;
          next_bitcnt = 4'h0;
        end
        gpio_exp_pkg::ST_RD:
        begin
          if (byte_done)
          begin
            next_state = gpio_exp_pkg::ST_RD_ACK;
            next_sda_low = 1'b0; // release for master ack
          end
          else
          begin
            next_shift = {shift[6:0], 1'b0};
            next_sda_low = ~shift[6];
            next_bitcnt = bitcnt + 4'h1;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // bus state registers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= gpio_exp_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      sda_low <= 1'b0;
      is_read <= 1'b0;
    end
    else if (soft_clr)
    begin
      state <= gpio_exp_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      sda_low <= 1'b0;
      is_read <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shift <= next_shift;
      sda_low <= next_sda_low;
      is_read <= next_is_read;
    end
  end

  // command and port registers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      command_pointer <= gpio_exp_pkg::COMMAND_RST;
      output_latch <= gpio_exp_pkg::OUTPUT_LATCH_RST;
      input_invert <= gpio_exp_pkg::INPUT_INVERT_RST;
      pin_direction <= gpio_exp_pkg::PIN_DIRECTION_RST;
    end
    else if (soft_clr)
    begin
      command_pointer <= gpio_exp_pkg::COMMAND_RST;
      output_latch <= gpio_exp_pkg::OUTPUT_LATCH_RST;
      input_invert <= gpio_exp_pkg::INPUT_INVERT_RST;
      pin_direction <= gpio_exp_pkg::PIN_DIRECTION_RST;
    end
    else if (cmd_load)
      command_pointer <= shift;
    else if (data_load)
    begin
      // writes to the pin level code are dropped
      if (sel_code == gpio_exp_pkg::SEL_OUTPUT_LATCH)
        output_latch <= shift;
      if (sel_code == gpio_exp_pkg::SEL_INPUT_INVERT)
        input_invert <= shift;
      if (sel_code == gpio_exp_pkg::SEL_PIN_DIRECTION)
        pin_direction <= shift;
    end
  end

  // change detector: reference level and interrupt
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      snapshot <= 8'h00;
      load_pins <= 8'h00;
      prime_sr <= 3'h0;
      int_active <= 1'b0;
    end
    else if (soft_clr || !primed)
    begin
      snapshot <= pin_s; // take reference once synchronisers are full
      load_pins <= pin_s;
      prime_sr <= soft_clr ? 3'h0 : {prime_sr[1:0], 1'b1};
      int_active <= 1'b0;
    end
    else
    begin
      if (read_load)
        load_pins <= pin_s;
      if (read_ack_clk && sel_code == gpio_exp_pkg::SEL_PIN_LEVEL)
        snapshot <= load_pins;
      int_active <= |changed;
    end
  end

  // pins and open-drain outputs
  assign port_pin_out = output_latch;
  assign port_pin_oe_out = ~pin_direction;
  assign bus.sda_dev_out = 1'b0;
  assign bus.sda_dev_oe = sda_low;
  assign bus.int_out = 1'b0;
  assign bus.int_oe = int_active;
endmodule

// file: verilog/io_expander_host.sv
`timescale 1ns/1ps
module io_expander_host #(
  parameter int QUARTER_CYCLES = gpio_exp_pkg::QUARTER_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  i2c_exp_if.host bus,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  logic sda_meta;
  logic sda_s;
  logic int_meta;
  logic int_s;
  logic [6:0] slave_addr;
  logic [7:0] command_val;
  logic [7:0] wdata_val;
  logic [7:0] rdata_val;
  logic op_read;
  logic busy;
  logic nack_seen;
  gpio_exp_pkg::host_op_e op;
  gpio_exp_pkg::host_op_e step_op;
  logic [2:0] step;
  logic [3:0] bitn;
  logic [1:0] phase;
  logic [15:0] qcnt;
  logic [8:0] tx9;
  logic [8:0] rx9;
  logic [8:0] step_word;
  logic want_scl_low;
  logic want_sda_low;
  logic scl_low;
  logic sda_low;

  // decodes
  wire tick = qcnt == 16'(QUARTER_CYCLES - 1);
  wire go = reg_wr_in & (reg_addr_in == gpio_exp_pkg::HREG_CTRL) & ~busy;
  wire elem_end = busy & tick & (phase == 2'h3);
  wire [2:0] stop_step = op_read ? 3'h6 : 3'h4;
  wire last_read = op_read & (step == 3'h5);
  wire xfer_last = (op == gpio_exp_pkg::H_XFER) & (bitn == gpio_exp_pkg::BITS_PER_BYTE);
  wire got_nack = xfer_last & ~last_read & rx9[0];
  wire [2:0] adv_step = got_nack ? stop_step : 3'(step + 3'h1);

  // transfer sequence table
  always_comb
  begin
    step_op = gpio_exp_pkg::H_XFER;
    step_word = 9'h1FF;
    case (step)
      3'h0: step_op = gpio_exp_pkg::H_START;
      3'h1: step_word = {slave_addr, 1'b0, 1'b1};
      3'h2: step_word = {command_val, 1'b1};
      3'h3:
      begin
        if (op_read)
          step_op = gpio_exp_pkg::H_START;
        else
          step_word = {wdata_val, 1'b1};
      end
      3'h4:
      begin
        if (op_read)
          step_word = {slave_addr, 1'b1, 1'b1};
        else
          step_op = gpio_exp_pkg::H_STOP;
      end
      3'h5: step_word = 9'h1FF;
      default: step_op = gpio_exp_pkg::H_STOP;
    endcase
  end

  // line levels per element and phase
  always_comb
  begin
    want_scl_low = 1'b0;
    want_sda_low = 1'b0;
    case (op)
      gpio_exp_pkg::H_START:
      begin
        // first start leaves scl high on the idle bus
        want_scl_low = ((phase == 2'h0) & (step != 3'h0)) | (phase == 2'h3);
        want_sda_low = phase[1];
      end
      gpio_exp_pkg::H_XFER:
      begin
        want_scl_low = (phase == 2'h0) | (phase == 2'h3);
        want_sda_low = ~tx9[8];
      end
      gpio_exp_pkg::H_STOP:
      begin
        want_scl_low = phase == 2'h0;
        want_sda_low = ~phase[1];
      end
      default:
      begin
      end
    endcase
  end

  // synchronisers and line drivers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {sda_meta, sda_s} <= 2'h3;
      {int_meta, int_s} <= 2'h3;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end
    else
    begin
      {sda_meta, sda_s} <= {bus.sda, sda_meta};
      {int_meta, int_s} <= {bus.int_n, int_meta};
      scl_low <= want_scl_low;
      sda_low <= want_sda_low;
    end
  end

  // quarter timer and element sequencer
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      op <= gpio_exp_pkg::H_IDLE;
      busy <= 1'b0;
      step <= 3'h0;
      bitn <= 4'h0;
      phase <= 2'h0;
      qcnt <= 16'h0000;
      tx9 <= 9'h1FF;
      rx9 <= 9'h000;
      nack_seen <= 1'b0;
      rdata_val <= 8'h00;
    end
    else if (go)
    begin
      busy <= 1'b1;
      op <= gpio_exp_pkg::H_START;
      step <= 3'h0;
      phase <= 2'h0;
      qcnt <= 16'h0000;
      nack_seen <= 1'b0;
    end
    else if (busy)
    begin
      qcnt <= tick ? 16'h0000 : 16'(qcnt + 16'h0001);
      if (tick)
        phase <= 2'(phase + 2'h1);
      if (tick && phase == 2'h2 && op == gpio_exp_pkg::H_XFER)
        rx9 <= {rx9[7:0], sda_s};
      if (elem_end && op == gpio_exp_pkg::H_XFER && !xfer_last)
      begin
        tx9 <= {tx9[7:0], 1'b1};
        bitn <= bitn + 4'h1;
      end
      else if (elem_end && op == gpio_exp_pkg::H_STOP)
      begin
        busy <= 1'b0;
        op <= gpio_exp_pkg::H_IDLE;
      end
      else if (elem_end)
      begin
        if (got_nack)
          nack_seen <= 1'b1;
        if (xfer_last && last_read)
          rdata_val <= rx9[8:1];
        step <= adv_step;
        bitn <= 4'h0;
      end
      else if (tick && phase == 2'h3)
        op <= op;
      // every element loads its own word, also byte after byte
      if (!elem_end && bitn == 4'h0 && phase == 2'h0 && qcnt == 16'h0000)
      begin
        op <= step_op;
        tx9 <= step_word;
      end
    end
  end

  // command port registers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      slave_addr <= gpio_exp_pkg::SLAVE_ADDR_BASE;
      command_val <= gpio_exp_pkg::COMMAND_RST;
      wdata_val <= 8'h00;
      op_read <= 1'b0;
      reg_rdata_out <= 8'h00;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == gpio_exp_pkg::HREG_SLAVE && !busy)
        slave_addr <= reg_wdata_in[6:0];
      if (reg_wr_in && reg_addr_in == gpio_exp_pkg::HREG_COMMAND && !busy)
        command_val <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == gpio_exp_pkg::HREG_WDATA && !busy)
        wdata_val <= reg_wdata_in;
      if (go)
        op_read <= reg_wdata_in[0];
      reg_rdata_out <= !reg_rd_in ? 8'h00 :
        (reg_addr_in == gpio_exp_pkg::HREG_SLAVE) ? {1'b0, slave_addr} :
        (reg_addr_in == gpio_exp_pkg::HREG_COMMAND) ? command_val :
        (reg_addr_in == gpio_exp_pkg::HREG_WDATA) ? wdata_val :
        (reg_addr_in == gpio_exp_pkg::HREG_STATUS) ? {5'h00, ~int_s, nack_seen, busy} :
        (reg_addr_in == gpio_exp_pkg::HREG_RDATA) ? rdata_val : 8'h00;
    end
  end

  // open-drain bus drive
  assign bus.scl_out = 1'b0;
  assign bus.scl_oe = scl_low;
  assign bus.sda_host_out = 1'b0;
  assign bus.sda_host_oe = sda_low;
endmodule

// file: testbench/i2c_eight_bit_io_expander_chk.sv
`timescale 1ns/1ps
module i2c_eight_bit_io_expander_chk #(
  parameter int QUARTER_CYCLES = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  logic prev_scl;
  logic prev_sda;
  logic frame;
  logic [15:0] hold_cnt;
  // who pulls sda low, and bus conditions
  wire host_pull = sda_host_oe & ~sda_host_out;
  wire dev_pull = sda_dev_oe & ~sda_dev_out;
  wire start_cond = scl & prev_scl & prev_sda & ~sda;
  wire stop_cond = scl & prev_scl & ~prev_sda & sda;
  wire scl_moved = scl ^ prev_scl;
  // frame tracking and scl hold counter
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      frame <= 1'b0;
      hold_cnt <= 16'h0000;
    end
    else
    begin
      prev_scl <= scl;
      prev_sda <= sda;
      frame <= start_cond | (frame & ~stop_cond);
      hold_cnt <= (scl_moved | ~frame) ? 16'h0000 : hold_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  scl_open_a: assert property (scl_oe |-> !scl_out) else $error("scl driven high");
  host_frame_a: assert property (scl_oe |-> frame) else $error("scl pulled outside frame");
  dev_frame_a: assert property (dev_pull |-> frame) else $error("sda pulled outside frame");
  dev_edge_a: assert property ($changed(dev_pull) |-> !scl)
    else $error("device moved sda with scl high");
  no_fight_a: assert property ((dev_pull && scl) |-> !host_pull)
    else $error("both pull sda");
  scl_high_a: assert property ($rose(scl) |-> scl[*8]) else $error("scl high too short");
  scl_low_a: assert property ($fell(scl) |-> (!scl)[*6]) else $error("scl low too short");
  progress_a: assert property (frame |-> hold_cnt < 8 * QUARTER_CYCLES)
    else $error("scl stalled in frame");
  // main scenarios seen
  start_c: cover property (start_cond);
  ack_c: cover property ($fell(dev_pull) ##[1:40] $rose(scl));
  stop_c: cover property (stop_cond);
endmodule

// file: testbench/i2c_eight_bit_io_expander_test.sv
`timescale 1ns/1ps
module i2c_eight_bit_io_expander_test;
  localparam int QUARTER = 8;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic addr_sel = 1'b0;
  logic reset_pin_n = 1'b1;
  logic [7:0] pins_ext = 8'h3C;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] stat;
  logic [7:0] val;
  logic [6:0] slave = 7'h20;
  int errors = 0;
  int comparisons = 0;
  // pin level seen by the device: its own drive or the outside world
  wire [7:0] pin_level = (pin_oe & pin_out) | (~pin_oe & pins_ext);
  always #5 clk_sys_in = ~clk_sys_in;
  i2c_exp_if i2c_exp_if_inst ();
  io_expander_dev io_expander_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .bus(i2c_exp_if_inst), .addr_sel_in(addr_sel), .reset_pin_n_in(reset_pin_n),
    .port_pin_in(pin_level), .port_pin_out(pin_out), .port_pin_oe_out(pin_oe));
  io_expander_host #(.QUARTER_CYCLES(QUARTER)) io_expander_host_inst (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .bus(i2c_exp_if_inst), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
  i2c_eight_bit_io_expander_chk #(.QUARTER_CYCLES(QUARTER)) chk_inst (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .scl_out(i2c_exp_if_inst.scl_out), .scl_oe(i2c_exp_if_inst.scl_oe),
    .sda_host_out(i2c_exp_if_inst.sda_host_out), .sda_host_oe(i2c_exp_if_inst.sda_host_oe),
    .sda_dev_out(i2c_exp_if_inst.sda_dev_out), .sda_dev_oe(i2c_exp_if_inst.sda_dev_oe),
    .scl(i2c_exp_if_inst.scl), .sda(i2c_exp_if_inst.sda));
  // byte comparison with count
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // host port write and read cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    @(negedge clk_sys_in);
    d = reg_rdata;
    @(posedge clk_sys_in);
  endtask
  // one bus transfer, polled until idle
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, input logic rd_op,
    input logic nack);
    int n;
    wr(gpio_exp_pkg::HREG_SLAVE, {1'b0, slave});
    wr(gpio_exp_pkg::HREG_COMMAND, cmd);
    wr(gpio_exp_pkg::HREG_WDATA, data);
    wr(gpio_exp_pkg::HREG_CTRL, {7'h00, rd_op});
    n = 0;
    stat = 8'h01;
    while (stat[0] !== 1'b0 && n < 2000)
    begin
      rd(gpio_exp_pkg::HREG_STATUS, stat);
      n++;
    end
    check8("busy", 8'h00, {7'h00, stat[0]});
    check8("nack", {7'h00, nack}, {7'h00, stat[1]});
  endtask
  task automatic dev_read(input logic [1:0] sel, input logic [7:0] exp, input string what);
    xfer({6'h00, sel}, 8'h00, 1'b1, 1'b0);
    rd(gpio_exp_pkg::HREG_RDATA, val);
    check8(what, exp, val);
  endtask
  task automatic dev_write(input logic [1:0] sel, input logic [7:0] data);
    xfer({6'h00, sel}, data, 1'b0, 1'b0);
  endtask
  // interrupt line wait, bounded
  task automatic wait_int(input logic exp);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    while (i2c_exp_if_inst.int_n !== exp && n < 20)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check8("int_n", {7'h00, exp}, {7'h00, i2c_exp_if_inst.int_n});
    @(posedge clk_sys_in);
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #800000;
    errors++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    dev_read(gpio_exp_pkg::SEL_OUTPUT_LATCH, 8'hFF, "latch rst");
    dev_read(gpio_exp_pkg::SEL_INPUT_INVERT, 8'h00, "invert rst");
    dev_read(gpio_exp_pkg::SEL_PIN_DIRECTION, 8'hFF, "dir rst");
    check8("oe rst", 8'h00, pin_oe);
    check8("int rst", 8'h01, {7'h00, i2c_exp_if_inst.int_n});
    dev_read(gpio_exp_pkg::SEL_PIN_LEVEL, 8'h3C, "level");
    dev_write(gpio_exp_pkg::SEL_PIN_DIRECTION, 8'h0F);
    dev_write(gpio_exp_pkg::SEL_OUTPUT_LATCH, 8'hA5);
    dev_write(gpio_exp_pkg::SEL_PIN_LEVEL, 8'h55);
    check8("oe", 8'hF0, pin_oe);
    check8("pins", 8'hA5, pin_out);
    dev_read(gpio_exp_pkg::SEL_OUTPUT_LATCH, 8'hA5, "latch");
    dev_read(gpio_exp_pkg::SEL_PIN_LEVEL, 8'hAC, "level mixed");
    dev_write(gpio_exp_pkg::SEL_INPUT_INVERT, 8'h0F);
    dev_read(gpio_exp_pkg::SEL_PIN_LEVEL, 8'hA3, "level inv");
    dev_read(gpio_exp_pkg::SEL_PIN_DIRECTION, 8'h0F, "dir");
    wait_int(1'b1);
    dev_write(gpio_exp_pkg::SEL_OUTPUT_LATCH, 8'h5A);
    repeat (20) @(posedge clk_sys_in);
    wait_int(1'b1);
    pins_ext <= 8'h3D;
    wait_int(1'b0);
    rd(gpio_exp_pkg::HREG_STATUS, stat);
    check8("int pending", 8'h04, stat & 8'h04);
    pins_ext <= 8'h3C;
    wait_int(1'b1);
    pins_ext <= 8'h38;
    wait_int(1'b0);
    dev_read(gpio_exp_pkg::SEL_PIN_LEVEL, 8'h57, "level int");
    wait_int(1'b1);
    addr_sel <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    xfer({6'h00, gpio_exp_pkg::SEL_OUTPUT_LATCH}, 8'h00, 1'b1, 1'b1);
    slave = 7'h21;
    dev_read(gpio_exp_pkg::SEL_OUTPUT_LATCH, 8'h5A, "latch alt");
    reset_pin_n <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    reset_pin_n <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    check8("oe pin rst", 8'h00, pin_oe);
    check8("pins pin rst", 8'hFF, pin_out);
    dev_read(gpio_exp_pkg::SEL_INPUT_INVERT, 8'h00, "invert pin rst");
    rd(3'h7, val);
    check8("unmapped", 8'h00, val);
    complete_run();
  end
endmodule
